/* File: logic/flash_block_protection.v */
// Flash array with unit erase, region protection and requester checks.
`timescale 1ns/1ps
`include "flash_prot_regs.vh"
module flash_block_protection (
    input  wire                      I_CLK_SYS,
    input  wire                      I_RST_N,
    input  wire                      I_REQ,
    input  wire [1:0]                I_SRC,
    input  wire [1:0]                I_OP,
    input  wire [`FP_ADDR_W-1:0]     I_ADDR,
    input  wire [31:0]               I_WDATA,
    input  wire                      I_PROT_WR,
    input  wire [`FP_REGION_W-1:0]   I_PROT_REGION,
    input  wire [1:0]                I_PROT_VAL,
    output reg                       O_DONE,
    output reg                       O_ERR,
    output reg  [31:0]               O_RDATA,
    output reg                       O_BUSY
);
    // ------------------------------------------------------------
    // State and storage
    // ------------------------------------------------------------
    localparam ST_IDLE  = 1'b0;
    localparam ST_ERASE = 1'b1;

    reg [31:0]                mem [0:`FP_WORDS-1];

    reg                       state_reg;
    reg                       state_next;
    reg [`FP_WORD_AW-1:0]     erase_ptr_reg;
    reg [`FP_WORD_AW-1:0]     erase_ptr_next;
    reg [7:0]                 erase_cnt_reg;
    reg [7:0]                 erase_cnt_next;

    reg                       done_next;
    reg                       err_next;
    reg [31:0]                rdata_next;
    reg                       busy_next;

    // ------------------------------------------------------------
    // Address and request decode
    // ------------------------------------------------------------
    wire [`FP_WORD_AW-1:0]    word_addr  = I_ADDR[`FP_ADDR_W-1:2];
    wire [`FP_REGION_W-1:0]   region     = word_addr[`FP_WORD_AW-1:`FP_REGION_SHIFT];
    wire [`FP_WORD_AW-1:0]    unit_base  = {word_addr[`FP_WORD_AW-1:`FP_UNIT_SHIFT], {`FP_UNIT_SHIFT{1'b0}}};
    wire                      in_range   = (word_addr < `FP_WORDS);

    wire                      op_read    = (I_OP == `FP_OP_READ);
    wire                      op_prog    = (I_OP == `FP_OP_PROG);
    wire                      op_erase   = (I_OP == `FP_OP_ERASE);
    wire                      idle       = (state_reg == ST_IDLE);
    wire                      erase_last = (erase_cnt_reg == `FP_ERASE_LAST);

    // ------------------------------------------------------------
    // Protection table, one entry per region
    // ------------------------------------------------------------
    // An entry can be set only once, from none, so software cannot unlock a region short of a reset.
    wire [2*`FP_REGIONS-1:0]  prot_flat;
    wire [1:0]                prot_sel;
    wire                      prot_val_ok = (I_PROT_VAL == `FP_PROT_RO) || (I_PROT_VAL == `FP_PROT_XO);
    genvar                    gi;

    generate
        for (gi = 0; gi < `FP_REGIONS; gi = gi + 1) begin : g_region
            reg  [1:0]        prot_reg;
            wire              hit = I_PROT_WR && prot_val_ok && (I_PROT_REGION == gi);

            always @(posedge I_CLK_SYS or negedge I_RST_N) begin
                if (!I_RST_N) begin
                    prot_reg <= `FP_PROT_NONE;
                end else if (hit && prot_reg == `FP_PROT_NONE) begin
                    prot_reg <= I_PROT_VAL;
                end
            end

            assign prot_flat[2*gi+1:2*gi] = prot_reg;
        end
    endgenerate

    // Out-of-range addresses pick no entry; the range check refuses them anyway.
    assign prot_sel = in_range ? prot_flat[2*region +: 2] : `FP_PROT_NONE;

    // ------------------------------------------------------------
    // Permission check
    // ------------------------------------------------------------
    wire                      allow;
    wire                      ok = allow && in_range;

    flash_prot_check flash_prot_check_i (
        .i_prot  (prot_sel),
        .i_src   (I_SRC),
        .i_op    (I_OP),
        .o_allow (allow)
    );

    // ------------------------------------------------------------
    // Array writes, kept free of reset so it can map to memory
    // ------------------------------------------------------------
    // The array has no reset of its own, so a program request seen while reset is held is dropped.
    wire                      erase_we = !idle;
    wire                      prog_we  = I_RST_N && idle && I_REQ && ok && op_prog;

    always @(posedge I_CLK_SYS) begin
        if (erase_we) begin
            mem[erase_ptr_reg] <= `FP_ERASED_WORD;
        end else if (prog_we) begin
            mem[word_addr] <= mem[word_addr] & I_WDATA;
        end
    end

    // ------------------------------------------------------------
    // Erase sequencer
    // ------------------------------------------------------------
    // Requests during an erase are ignored; the caller waits for busy to drop.
    always @* begin
        state_next     = state_reg;
        erase_ptr_next = erase_ptr_reg;
        erase_cnt_next = erase_cnt_reg;
        busy_next      = O_BUSY;

        case (state_reg)
            ST_IDLE: begin
                if (I_REQ && ok && op_erase) begin
                    state_next     = ST_ERASE;
                    erase_ptr_next = unit_base;
                    erase_cnt_next = 8'h00;
                    busy_next      = 1'b1;
                end
            end
            ST_ERASE: begin
                erase_ptr_next = erase_ptr_reg + 1'b1;
                erase_cnt_next = erase_cnt_reg + 8'h01;
                if (erase_last) begin
                    state_next = ST_IDLE;
                    busy_next  = 1'b0;
                end
            end
            default: begin
                state_next = ST_IDLE;
                busy_next  = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------
    // Read data holds between answers, so a slow requester may still pick it up.
    always @* begin
        done_next  = 1'b0;
        err_next   = 1'b0;
        rdata_next = O_RDATA;

        case (state_reg)
            ST_IDLE: begin
                if (I_REQ) begin
                    if (!ok) begin
                        err_next   = 1'b1;
                        rdata_next = 32'h00000000;
                    end else if (op_read) begin
                        done_next  = 1'b1;
                        rdata_next = mem[word_addr];
                    end else if (op_prog) begin
                        done_next  = 1'b1;
                    end
                end
            end
            ST_ERASE: begin
                if (erase_last) begin
                    done_next = 1'b1;
                end
            end
            default: begin
                done_next = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer registers
    // ------------------------------------------------------------
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg     <= ST_IDLE;
            erase_ptr_reg <= {`FP_WORD_AW{1'b0}};
            erase_cnt_reg <= 8'h00;
        end else begin
            state_reg     <= state_next;
            erase_ptr_reg <= erase_ptr_next;
            erase_cnt_reg <= erase_cnt_next;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Every output leaves a flip-flop, so a requester never sees a decode glitch.
    always @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_DONE  <= 1'b0;
            O_ERR   <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_BUSY  <= 1'b0;
        end else begin
            O_DONE  <= done_next;
            O_ERR   <= err_next;
            O_RDATA <= rdata_next;
            O_BUSY  <= busy_next;
        end
    end
endmodule

/* File: logic/flash_prot_check.v */
// Permission check for one access against the protection state of its region.
`timescale 1ns/1ps
`include "flash_prot_regs.vh"
module flash_prot_check (
    input  wire [1:0] i_prot,
    input  wire [1:0] i_src,
    input  wire [1:0] i_op,
    output reg        o_allow
);
    always @* begin
        o_allow = 1'b1;
        if (i_op == `FP_OP_PROG || i_op == `FP_OP_ERASE) begin
            if (i_prot == `FP_PROT_RO || i_prot == `FP_PROT_XO) begin
                o_allow = 1'b0;
            end
        end else if (i_op == `FP_OP_READ) begin
            if (i_prot == `FP_PROT_XO && i_src != `FP_SRC_FETCH) begin
                o_allow = 1'b0;
            end
        end else begin
            o_allow = 1'b0;
        end
    end
endmodule

/* File: logic/flash_prot_regs.vh */
// Constants for the flash access and protection block.
`ifndef FLASH_PROT_REGS_VH
`define FLASH_PROT_REGS_VH
`define FP_ADDR_W        17
`define FP_WORD_AW       15
`define FP_WORDS         24576
`define FP_UNIT_WORDS    256
`define FP_UNIT_SHIFT    8
`define FP_ERASE_LAST    8'hFF
`define FP_UNITS         96
`define FP_REGION_SHIFT  9
`define FP_REGIONS       48
`define FP_REGION_W      6
`define FP_ERASED_WORD   32'hFFFFFFFF
`define FP_PROT_NONE     2'h0
`define FP_PROT_RO       2'h1
`define FP_PROT_XO       2'h2
`define FP_SRC_FETCH     2'h0
`define FP_SRC_DATA      2'h1
`define FP_SRC_DEBUG     2'h2
`define FP_OP_READ       2'h0
`define FP_OP_PROG       2'h1
`define FP_OP_ERASE      2'h2
`endif

/* File: sim/flash_block_protection_asserts.sv */
// Port checker for the flash protection block.
`timescale 1ns/1ps
module flash_block_protection_asserts (
    input wire logic        I_CLK_SYS, I_RST_N, I_REQ, O_DONE, O_ERR, O_BUSY,
    input wire logic [1:0]  I_OP,
    input wire logic [31:0] O_RDATA
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    wire take = I_REQ && !O_BUSY;
    AST_READ_ANS: assert property (take && I_OP == 2'h0 |=> O_DONE != O_ERR) else $error("read unanswered");
    AST_BAD_OP: assert property (take && I_OP == 2'h3 |=> O_ERR) else $error("bad op taken");
    AST_ERASE_GO: assert property (take && I_OP == 2'h2 |=> O_BUSY != O_ERR) else $error("erase lost");
    AST_ERASE_LEN: assert property ($rose(O_BUSY) |-> ##256 O_DONE && !O_BUSY) else $error("erase length");
    AST_ONE_ANS: assert property (!(O_DONE && O_ERR)) else $error("done with error");
    AST_ERR_ZERO: assert property (O_ERR |-> O_RDATA == 32'h0) else $error("data on error");
    AST_NO_SPONT: assert property (O_DONE |-> $past(take) || $fell(O_BUSY)) else $error("stray done");
    AST_BUSY_QUIET: assert property (O_BUSY |=> !O_ERR) else $error("error while busy");
    AST_RDATA_HOLD: assert property (!O_DONE && !O_ERR |-> $stable(O_RDATA)) else $error("data moved");
    cover property (take && I_OP == 2'h0 ##1 O_DONE);
    cover property ($fell(O_BUSY) && O_DONE);
    cover property (O_ERR);
endmodule
bind flash_block_protection flash_block_protection_asserts flash_block_protection_asserts_i (
    .I_CLK_SYS, .I_RST_N, .I_REQ, .O_DONE, .O_ERR, .O_BUSY, .I_OP, .O_RDATA);

/* File: sim/flash_block_protection_tb.sv */
// Self-checking bench for the flash protection block.
`timescale 1ns/1ps
module flash_block_protection_tb;
    logic clk = 0, rst_n = 0, pwr = 0, req, done, err, busy;
    logic [5:0]  preg = 0;
    logic [1:0]  pval = 0, src, op;
    logic [16:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [33:0] q[$], e;
    localparam logic [33:0] ER = {2'b11, 32'h0}, ONES = {2'b10, 32'hFFFFFFFF};
    int bad_count = 0, n_checks = 0, cyc = 0, g, h;
    initial forever #5 clk = ~clk;
    flash_requester flash_requester_i (.clk(clk), .req(req), .src(src), .op(op), .addr(addr), .wdata(wdata));
    flash_block_protection flash_block_protection_i (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_REQ(req),
        .I_SRC(src), .I_OP(op), .I_ADDR(addr), .I_WDATA(wdata), .I_PROT_WR(pwr), .I_PROT_REGION(preg),
        .I_PROT_VAL(pval), .O_DONE(done), .O_ERR(err), .O_RDATA(rdata), .O_BUSY(busy));
    task check(input logic [32:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Expectation is {compare data, error, data}; erase waits out busy.
    task go(input logic [1:0] s, o, input int a, input logic [31:0] dd, input logic [33:0] x);
        q.push_back(x);
        flash_requester_i.issue(s, o, a[16:0], dd);
        do @(negedge clk); while (busy);
    endtask
    task prot(input int r, input logic [1:0] v);
        @(posedge clk);
        {pwr, preg, pval} <= {1'b1, r[5:0], v};
        @(posedge clk);
        pwr <= 0;
    endtask
    always @(negedge clk) if (done || err) begin
        if (q.size() == 0) check(33'h1, 33'h0);
        e = (q.size() != 0) ? q.pop_front() : 34'h0;
        check({err, rdata & {32{e[33]}}}, e[32:0]);
    end
    always @(posedge clk) if (++cyc == 5000) begin
        bad_count++;
        print_verdict;
    end
    initial begin
        void'($urandom(32'h91FCFC57));
        repeat (16) @(posedge clk);
        rst_n <= 1;
        g = $urandom % 47;
        h = g + 1;
        d = $urandom;
        go(0, 2, g * 2048, 0, 0);
        go(1, 0, g * 2048 + 4, 0, ONES);
        go(1, 1, g * 2048 + 4, d, 0);
        go(2, 0, g * 2048 + 4, 0, {2'b10, d});
        prot(g, 1);
        go(1, 1, g * 2048 + 8, 0, ER);
        go(1, 2, g * 2048 + 1024, 0, ER);
        go(1, 2, h * 2048 + 1024, 0, 0);
        go(1, 0, g * 2048 + 4, 0, {2'b10, d});
        prot(h, 2);
        go(0, 0, h * 2048 + 1024, 0, ONES);
        for (int s = 1; s < 3; s++) go(s[1:0], 0, h * 2048 + 1024, 0, ER);
        go(0, 1, h * 2048 + 1024, 0, ER);
        go(0, 3, g * 2048, 0, ER);
        @(posedge clk);
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        go(1, 1, g * 2048 + 8, d, 0);
        go(1, 0, g * 2048 + 8, 0, {2'b10, d});
        @(posedge clk);
        check(q.size(), 0);
        print_verdict;
    end
endmodule

/* File: sim/flash_requester.sv */
// Requester model for the fetch, data and debugger paths.
`timescale 1ns/1ps
module flash_requester (
    input  wire logic   clk,
    output logic        req,
    output logic [1:0]  src, op,
    output logic [16:0] addr,
    output logic [31:0] wdata
);
    initial {req, src, op, addr, wdata} = 0;
    // A released bus shows the inverse, so stale values never pass for good ones.
    task automatic issue(input logic [1:0] s, o, input logic [16:0] a, input logic [31:0] d);
        @(posedge clk);
        {req, src, op, addr, wdata} <= {1'b1, s, o, a, d};
        @(posedge clk);
        {req, src, op, addr, wdata} <= {1'b0, ~s, ~o, ~a, ~d};
    endtask
endmodule
